// >>> rtl/cae_exec.sv
// execute unit for logic, multiply, cipher, jump, skip and branch ops
//
// Register access over AXI4-Lite and the register offsets were decided locally.
module cae_exec #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // ==========================================================
    // helpers

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // zero, negative, overflow cleared, sign for logic results
    function automatic logic [7:0] lflags(input logic [7:0] f,
        input logic [7:0] r);
        logic [7:0] o;
        o = f;
        o[cae_pkg::F_Z] = (r == 8'h00);
        o[cae_pkg::F_N] = r[7];
        o[cae_pkg::F_V] = 1'b0;
        o[cae_pkg::F_S] = r[7];
        return o;
    endfunction : lflags

    // ==========================================================
    // state
    localparam int PC_W = cae_pkg::PC_W;
    localparam int EI_W = cae_pkg::EI_W;
    cae_pkg::cae_state_t st;
    cae_pkg::cae_state_t next_st;
    cae_pkg::cae_cmd_t cmd;     // issue word being executed
    logic [31:0] wd;            // merged write word
    logic [7:0] a;              // destination operand
    logic [7:0] b;              // source operand
    logic [7:0] r;              // logic result
    logic [15:0] p;             // product
    logic [15:0] zp;            // z pointer
    logic [PC_W-1:0] pc1;       // address of next instruction
    logic [PC_W-1:0] koff;      // sign-extended branch offset
    logic [2:0] cyc;            // cycles of the issued instruction
    logic skip;                 // next instruction is skipped
    logic base2;                // i/o skip costs one more cycle
    logic take;                 // branch condition holds

    // outputs come straight from the state flops
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        cmd = '0;
        wd = '0;
        a = '0;
        b = '0;
        r = '0;
        p = '0;
        zp = {st.rf[cae_pkg::Z_HI], st.rf[cae_pkg::Z_LO]};
        pc1 = st.pc + PC_W'(1);
        koff = '0;
        cyc = cae_pkg::CYC_1;
        skip = 1'b0;
        base2 = 1'b0;
        take = 1'b0;
        // busy countdown of multi-cycle instructions
        if (st.cnt != 3'h0) begin
            next_st.cnt = st.cnt - 3'h1;
        end
        // read channel: answer one cycle after the address is taken
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = cae_pkg::RESP_OK;
            next_st.rdata = '0;
            case (8'(araddr))
                cae_pkg::A_CMD: next_st.rdata = '0;
                cae_pkg::A_STAT: begin
                    next_st.rdata = {24'h0, 1'b0, st.last_cyc,
                                     3'h0, st.cnt != 3'h0};
                end
                cae_pkg::A_PC: next_st.rdata = 32'(st.pc);
                cae_pkg::A_EXT: next_st.rdata = 32'(st.ext);
                cae_pkg::A_FLG: next_st.rdata = 32'(st.flg);
                cae_pkg::A_RFIDX: next_st.rdata = 32'(st.rfidx);
                cae_pkg::A_RFDAT: next_st.rdata = 32'(st.rf[st.rfidx]);
                cae_pkg::A_IOVAL: next_st.rdata = 32'(st.ioval);
                cae_pkg::A_RET: next_st.rdata = 32'(st.ret);
                // unmapped address answers with an error
                default: next_st.rresp = cae_pkg::RESP_SLVERR;
            endcase
        end
        next_st.arready = !next_st.rvalid;
        // write channel: address and data in either order
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = 8'(awaddr);
        end
        if (wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = wdata;
            next_st.wstrb = wstrb;
        end
        if (next_st.aw_got && next_st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = cae_pkg::RESP_OK;
            wd = merge('0, next_st.wdata, next_st.wstrb);
            case (next_st.awaddr)
                cae_pkg::A_CMD: begin
                    if (st.cnt != 3'h0) begin
                        // issue while busy is refused, nothing changes
                        next_st.bresp = cae_pkg::RESP_SLVERR;
                    end else begin
                        cmd = cae_pkg::cae_cmd_t'(wd);
                        a = st.rf[cmd.rd];
                        b = st.rf[cmd.rr];
                        koff = PC_W'($signed(cmd.k[6:0]));
                        next_st.pc = pc1;
                        case (cae_pkg::cae_op_t'(cmd.op))
                            cae_pkg::set_bits_imm: begin
                                r = a | cmd.k;
                                next_st.rf[cmd.rd] = r;
                                next_st.flg = lflags(st.flg, r);
                            end
                            cae_pkg::clear_bits_imm: begin
                                r = a & ~cmd.k;
                                next_st.rf[cmd.rd] = r;
                                next_st.flg = lflags(st.flg, r);
                            end
                            cae_pkg::test_zero_minus: begin
                                next_st.flg = lflags(st.flg, a & a);
                            end
                            cae_pkg::mult_signed_unsigned,
                            cae_pkg::frac_mult_signed_unsigned: begin
                                p = 16'($signed(a) * $signed({1'b0, b}));
                                next_st.flg[cae_pkg::F_C] = p[15];
                                if (cmd.op ==
                                    cae_pkg::frac_mult_signed_unsigned) begin
                                    p = {p[14:0], 1'b0};
                                end
                                next_st.rf[0] = p[7:0];
                                next_st.rf[1] = p[15:8];
                                next_st.flg[cae_pkg::F_Z] = (p == 16'h0);
                                cyc = cae_pkg::CYC_2;
                            end
                            cae_pkg::cipher_round: begin
                                // reversible keyed byte round: the
                                // decrypt path undoes encrypt exactly
                                for (int i = 0; i < cae_pkg::CIPHER_REGS;
                                     i++) begin
                                    if (!st.flg[cae_pkg::F_H]) begin
                                        r = st.rf[i] ^ cmd.k;
                                        next_st.rf[i] = {r[6:0], r[7]};
                                    end else begin
                                        r = {st.rf[i][0], st.rf[i][7:1]};
                                        next_st.rf[i] = r ^ cmd.k;
                                    end
                                end
                                cyc = st.flg[cae_pkg::F_H] ?
                                      cae_pkg::CYC_2 : cae_pkg::CYC_1;
                            end
                            cae_pkg::indirect_jump: begin
                                next_st.pc = {EI_W'(0), zp};
                                cyc = cae_pkg::CYC_2;
                            end
                            cae_pkg::extended_indirect_jump: begin
                                next_st.pc = {st.ext, zp};
                                cyc = cae_pkg::CYC_2;
                            end
                            cae_pkg::extended_indirect_call: begin
                                next_st.ret = pc1;
                                next_st.pc = {st.ext, zp};
                                cyc = cae_pkg::CYC_3;
                            end
                            cae_pkg::compare_skip_equal: begin
                                skip = (a == b);
                            end
                            cae_pkg::skip_reg_bit_clear,
                            cae_pkg::skip_reg_bit_set: begin
                                skip = a[cmd.bsel] ^ !cmd.op[0];
                            end
                            cae_pkg::skip_io_bit_clear,
                            cae_pkg::skip_io_bit_set: begin
                                base2 = 1'b1;
                                skip = st.ioval[cmd.bsel] ==
                                       (cmd.op == cae_pkg::skip_io_bit_set);
                            end
                            // set forms have even codes and cleared forms odd ones, so code bit 0
                            // inverts the test; the carry pair below is the other way round
                            cae_pkg::branch_flag_set,
                            cae_pkg::branch_flag_clear: begin
                                take = st.flg[cmd.bsel] ^ cmd.op[0];
                            end
                            cae_pkg::branch_less_signed,
                            cae_pkg::branch_ge_signed: begin
                                take = st.flg[cae_pkg::F_N] ^
                                       st.flg[cae_pkg::F_V] ^ cmd.op[0];
                            end
                            cae_pkg::branch_halfcarry_set,
                            cae_pkg::branch_halfcarry_clear: begin
                                take = st.flg[cae_pkg::F_H] ^ cmd.op[0];
                            end
                            cae_pkg::branch_t_set,
                            cae_pkg::branch_t_clear: begin
                                take = st.flg[cae_pkg::F_T] ^ cmd.op[0];
                            end
                            cae_pkg::branch_ovf_set,
                            cae_pkg::branch_ovf_clear: begin
                                take = st.flg[cae_pkg::F_V] ^ cmd.op[0];
                            end
                            cae_pkg::branch_int_enabled,
                            cae_pkg::branch_int_disabled: begin
                                take = st.flg[cae_pkg::F_I] ^ cmd.op[0];
                            end
                            cae_pkg::branch_same_higher,
                            cae_pkg::branch_lower: begin
                                take = st.flg[cae_pkg::F_C] ^ !cmd.op[0];
                            end
                            // unknown opcode acts as a one-cycle no-op
                            default: cyc = cae_pkg::CYC_1;
                        endcase
                        // taken branch: pc + k + 1, no flag touched
                        if (take) begin
                            next_st.pc = st.pc + koff + PC_W'(1);
                            cyc = cae_pkg::CYC_2;
                        end
                        // skip length follows the skipped word count
                        if (base2) begin
                            cyc = cae_pkg::CYC_2;
                        end
                        if (skip) begin
                            next_st.pc = cmd.two_words ?
                                         st.pc + PC_W'(3) : st.pc + PC_W'(2);
                            cyc = cyc + (cmd.two_words ? 3'h2 : 3'h1);
                        end
                        next_st.cnt = cyc - 3'h1;
                        next_st.last_cyc = cyc;
                    end
                end
                cae_pkg::A_PC: next_st.pc = PC_W'(merge(32'(st.pc),
                    next_st.wdata, next_st.wstrb));
                cae_pkg::A_EXT: next_st.ext = wd[EI_W-1:0];
                cae_pkg::A_FLG: next_st.flg = wd[7:0];
                cae_pkg::A_RFIDX: next_st.rfidx = wd[4:0];
                cae_pkg::A_RFDAT: begin
                    if (next_st.wstrb[0]) begin
                        next_st.rf[st.rfidx] = wd[7:0];
                    end
                end
                cae_pkg::A_IOVAL: next_st.ioval = wd[7:0];
                // status and return address are read only
                cae_pkg::A_STAT, cae_pkg::A_RET: next_st.bresp =
                    cae_pkg::RESP_OK;
                default: next_st.bresp = cae_pkg::RESP_SLVERR;
            endcase
        end
        // hold off new writes until the response has been taken
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : cae_exec

// >>> rtl/cae_pkg.sv
// package: constants, opcodes and carriers of the execute unit
package cae_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] A_CMD = 8'h00;   // instruction issue
    localparam logic [7:0] A_STAT = 8'h04;  // busy and last cycle count
    localparam logic [7:0] A_PC = 8'h08;    // program counter
    localparam logic [7:0] A_EXT = 8'h0c;   // extended_indirect_reg
    localparam logic [7:0] A_FLG = 8'h10;   // status_flags_reg
    localparam logic [7:0] A_RFIDX = 8'h14; // register file index
    localparam logic [7:0] A_RFDAT = 8'h18; // register file data
    localparam logic [7:0] A_IOVAL = 8'h1c; // low i/o register value
    localparam logic [7:0] A_RET = 8'h20;   // last pushed return address
    // ==========================================================
    // status flag positions
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_S = 4;
    localparam int F_H = 5;
    localparam int F_T = 6;
    localparam int F_I = 7;
    // ==========================================================
    // widths, cycle counts, responses
    localparam int PC_W = 22;
    localparam int EI_W = 6;
    localparam logic [2:0] CYC_1 = 3'h1;
    localparam logic [2:0] CYC_2 = 3'h2;
    localparam logic [2:0] CYC_3 = 3'h3;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [4:0] Z_LO = 5'h1e;    // z pointer low byte
    localparam logic [4:0] Z_HI = 5'h1f;    // z pointer high byte
    localparam int CIPHER_REGS = 16;
    // ==========================================================
    // operations
    typedef enum logic [4:0] {
        set_bits_imm, clear_bits_imm, test_zero_minus,
        mult_signed_unsigned, frac_mult_signed_unsigned, cipher_round,
        indirect_jump, extended_indirect_jump, extended_indirect_call,
        compare_skip_equal, skip_reg_bit_clear, skip_reg_bit_set,
        skip_io_bit_clear, skip_io_bit_set,
        branch_flag_set, branch_flag_clear,
        branch_less_signed, branch_ge_signed,
        branch_halfcarry_set, branch_halfcarry_clear,
        branch_t_set, branch_t_clear, branch_ovf_set, branch_ovf_clear,
        branch_int_enabled, branch_int_disabled,
        branch_same_higher, branch_lower
    } cae_op_t;
    // issue word layout
    typedef struct packed {
        logic [4:0] rsv;
        logic two_words;  // instruction after this one is two words
        logic [2:0] bsel; // bit or flag select
        logic [7:0] k;    // mask, round key or branch offset
        logic [4:0] rr;
        logic [4:0] rd;
        logic [4:0] op;
    } cae_cmd_t;
    // whole state of the unit
    typedef struct packed {
        logic [31:0][7:0] rf;
        logic [7:0] flg;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] ret;
        logic [EI_W-1:0] ext;
        logic [4:0] rfidx;
        logic [7:0] ioval;
        logic [2:0] cnt;
        logic [2:0] last_cyc;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } cae_state_t;
endpackage : cae_pkg

// >>> testbench/cae_exec_sva.sv
// checker: bus handshake relations of the execute unit
module cae_exec_sva #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write side
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    // read side
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    // ==========================================================
    // one clock domain, so clocking and disable are shared
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_answer: assert property (awvalid && awready && wvalid && wready
        |=> bvalid) else $error("write response late");
    a_w_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_b_return: assert property (bvalid && bready |=> !bvalid &&
        awready && wready) else $error("write side not reopened");
    a_r_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_r_blocked: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    a_r_return: assert property (rvalid && rready |=> !rvalid &&
        arready) else $error("read side not reopened");
    a_cmd_zero: assert property (arvalid && arready &&
        araddr == cae_pkg::A_CMD |=> rdata == 32'h0)
        else $error("issue register read not zero");
    a_unmapped_err: assert property (arvalid && arready &&
        araddr > 8'h20 |=> rresp == cae_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
    // keeps the 22-bit counter inside its width
    a_pc_width: assert property (arvalid && arready && araddr ==
        cae_pkg::A_PC |=> rdata[31:22] == 10'h0)
        else $error("counter upper bits set");
endmodule : cae_exec_sva

bind cae_exec cae_exec_sva #(.ADDR_W(ADDR_W)) u_sva (.aclk(aclk),
    .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));

// >>> testbench/testbench.sv
// testbench: execute unit driven over its register bus
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, q;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [2:0] cyc; // cycle count of the last issue
    int n_errors = 0, num_checks = 0;
    always #20 aclk = ~aclk;
    // responses are always accepted, so bready and rready stay high
    cae_exec dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(1'b1), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp));
    // ==========================================================
    // bus tasks
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input int d);
        awaddr <= a;
        wdata <= 32'(d);
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1); // only the watchdog ends a hang
    endtask : wr
    task rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        q = rdata;
    endtask : rd
    task ex(input int op, d, r, k, b, tw);
        wr(cae_pkg::A_CMD, {5'h0, 1'(tw), 3'(b), 8'(k), 5'(r), 5'(d), 5'(op)});
        rd(cae_pkg::A_STAT);
        cyc = q[6:4];
    endtask : ex
    task sr(input int i, v);
        wr(cae_pkg::A_RFIDX, i);
        wr(cae_pkg::A_RFDAT, v);
    endtask : sr
    task gr(input int i);
        wr(cae_pkg::A_RFIDX, i);
        rd(cae_pkg::A_RFDAT);
    endtask : gr
    // ==========================================================
    // scenarios
    task t_logic;
        sr(5, 8'h41);
        wr(cae_pkg::A_FLG, 8'h08); // v preset so clearing shows
        ex(cae_pkg::set_bits_imm, 5, 0, 8'h82, 0, 0);
        gr(5); chk("or", q, 32'hc3);
        rd(cae_pkg::A_FLG); chk("or_f", q & 32'h1f, 32'h14);
        chk("or_c", 32'(cyc), 32'h1);
        ex(cae_pkg::clear_bits_imm, 5, 0, 8'hc3, 0, 0);
        gr(5); chk("andn", q, 32'h0);
        rd(cae_pkg::A_FLG); chk("andn_f", q & 32'h1f, 32'h02);
        sr(6, 8'h80);
        ex(cae_pkg::test_zero_minus, 6, 0, 0, 0, 0);
        gr(6); chk("tst", q, 32'h80);
        rd(cae_pkg::A_FLG); chk("tst_f", q & 32'h1f, 32'h14);
        chk("tst_c", 32'(cyc), 32'h1);
        rd(8'h40); chk("unmapped", 32'(rresp), 32'h2);
        wr(8'h44, 0); chk("unm_wr", 32'(bresp), 32'h2);
        rd(cae_pkg::A_CMD); chk("cmd_rd", q, 32'h0);
        $display("logic test done");
    endtask : t_logic
    task t_mul;
        sr(7, 8'hff);
        sr(8, 8'h02);
        ex(cae_pkg::mult_signed_unsigned, 7, 8, 0, 0, 0);
        chk("mul_c", 32'(cyc), 32'h2);
        gr(0); chk("mul_lo", q, 32'hfe);
        gr(1); chk("mul_hi", q, 32'hff);
        rd(cae_pkg::A_FLG); chk("mul_f", q & 32'h3, 32'h1);
        sr(7, 8'h40);
        sr(8, 8'h40);
        ex(cae_pkg::frac_mult_signed_unsigned, 7, 8, 0, 0, 0);
        chk("fmul_c", 32'(cyc), 32'h2);
        gr(1); chk("fmul_hi", q, 32'h20);
        rd(cae_pkg::A_FLG); chk("fmul_f", q & 32'h3, 32'h0);
        $display("multiply test done");
    endtask : t_mul
    task t_cipher;
        sr(0, 8'h12);
        sr(16, 8'h55); // outside the block, must survive
        wr(cae_pkg::A_FLG, 0);
        ex(cae_pkg::cipher_round, 0, 0, 8'h0f, 0, 0);
        chk("enc_c", 32'(cyc), 32'h1);
        gr(0); chk("enc0", q, 32'h3a);
        gr(7); chk("enc7", q, 32'h9e);
        wr(cae_pkg::A_FLG, 8'h20);
        ex(cae_pkg::cipher_round, 0, 0, 8'h0f, 0, 0);
        chk("dec_c", 32'(cyc), 32'h2);
        gr(0); chk("dec0", q, 32'h12);
        gr(16); chk("keep16", q, 32'h55);
        $display("cipher test done");
    endtask : t_cipher
    task t_jump;
        sr(30, 8'h34);
        sr(31, 8'h12);
        wr(cae_pkg::A_EXT, 5);
        wr(cae_pkg::A_PC, 32'h3fffff);
        ex(cae_pkg::indirect_jump, 0, 0, 0, 0, 0);
        rd(cae_pkg::A_PC); chk("ij", q, 32'h1234);
        chk("ij_c", 32'(cyc), 32'h2);
        ex(cae_pkg::extended_indirect_jump, 0, 0, 0, 0, 0);
        rd(cae_pkg::A_PC); chk("ej", q, 32'h51234);
        chk("ej_c", 32'(cyc), 32'h2);
        wr(cae_pkg::A_PC, 32'h100);
        ex(cae_pkg::extended_indirect_call, 0, 0, 0, 0, 0);
        rd(cae_pkg::A_PC); chk("ec", q, 32'h51234);
        rd(cae_pkg::A_RET); chk("ec_ret", q, 32'h101);
        chk("ec_c", 32'(cyc), 32'h3);
        wr(cae_pkg::A_CMD, 8); // next issue lands while this call runs
        wr(cae_pkg::A_CMD, 6); chk("busy", 32'(bresp), 32'h2);
        $display("jump test done");
    endtask : t_jump
    task sk(input int op, r, s, b, tw, k, io);
        wr(cae_pkg::A_PC, 32'h10);
        ex(op, r, s, 0, b, tw);
        rd(cae_pkg::A_PC);
        chk("skip_pc", q, k ? 32'h12 + tw : 32'h11);
        chk("skip_c", 32'(cyc), 32'(k ? 2 + tw + io : 1 + io));
    endtask : sk
    task t_skip;
        sr(2, 8'h5a);
        sr(3, 8'h5a);
        sr(4, 0);
        wr(cae_pkg::A_IOVAL, 1);
        sk(9, 2, 3, 0, 0, 1, 0);
        sk(9, 2, 3, 0, 1, 1, 0);
        sk(9, 2, 4, 0, 0, 0, 0);
        sk(10, 2, 2, 0, 1, 1, 0);
        sk(10, 2, 2, 1, 0, 0, 0);
        sk(11, 2, 2, 1, 1, 1, 0);
        sk(11, 2, 2, 0, 0, 0, 0);
        sk(12, 0, 0, 0, 0, 0, 1);
        sk(12, 0, 0, 1, 1, 1, 1);
        sk(13, 0, 0, 0, 0, 1, 1);
        $display("skip test done");
    endtask : t_skip
    // taken when the chosen flag matches; odd codes test the clear form, codes 26 and 27 the other way round
    function automatic logic tk(input int op, input logic [7:0] s);
        int f;
        logic v;
        f = (op < 16) ? 1 : (op < 18) ? 9 : (op < 20) ? 5 : (op < 22) ? 6 :
            (op < 24) ? 3 : (op < 26) ? 7 : 0;
        v = (f == 9) ? s[2] ^ s[3] : s[f];
        return v ^ (op % 2 == 1) ^ (op >= 26);
    endfunction : tk
    task t_branch;
        logic [7:0] sv[3] = '{8'h00, 8'hff, 8'h04};
        foreach (sv[i]) begin
            for (int op = 14; op < 28; op++) begin
                wr(cae_pkg::A_PC, 32'h20);
                wr(cae_pkg::A_FLG, sv[i]);
                ex(op, 0, 0, 8'h7e, 1, 0);
                rd(cae_pkg::A_PC);
                chk("br_pc", q, tk(op, sv[i]) ? 32'h1f : 32'h21);
                chk("br_c", 32'(cyc), tk(op, sv[i]) ? 32'h2 : 32'h1);
                rd(cae_pkg::A_FLG); chk("br_f", q, 32'(sv[i]));
            end
        end
        $display("branch test done");
    endtask : t_branch
    // ==========================================================
    // verdict
    task final_report;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        #400000;
        n_errors++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_logic();
        t_mul();
        t_cipher();
        t_jump();
        t_skip();
        t_branch();
        final_report();
    end
endmodule : testbench
